// ### rtl/dtc_timer.sv
// Dual 16-bit capture and PWM timer with a classic Wishbone register slave.
`timescale 1ns/100ps
`default_nettype none
module dtc_timer (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [1:0]  cap_in,
    output logic      [1:0]  pwm_out,
    output logic             irq
);
    // ========================================================================
    // Register storage.
    logic [2:0]  cfg_r;
    logic [3:0]  mode_r   [2];
    logic [15:0] ctl_r;
    logic [15:0] imask_r;
    logic [15:0] raw_r;
    logic [31:0] reload_r [2];
    logic [31:0] cmp_r    [2];
    logic [31:0] div_r    [2];
    logic [31:0] dbc_r;
    logic [31:0] count_r  [2];
    logic [15:0] cnt_r    [2];
    logic [1:0]  run_r;
    logic [1:0]  up_r;
    logic [1:0]  pwm_r;
    logic [15:0] evt_left_r [2];
    logic [31:0] rdata_r;
    logic        ack_r;
    logic        irq_r;
    logic [1:0]  run_done;

    // ========================================================================
    // Bus decode.
    function automatic logic [31:0] wmask(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    wire        req      = wb_cyc_i & wb_stb_i & ~ack_r;
    wire        wr       = req & wb_we_i;
    wire        wr_cfg   = wr && wb_adr_i == dtc_pkg::OFS_CFG;
    wire        wr_amode = wr && wb_adr_i == dtc_pkg::OFS_AMODE;
    wire        wr_bmode = wr && wb_adr_i == dtc_pkg::OFS_BMODE;
    wire        wr_ctl   = wr && wb_adr_i == dtc_pkg::OFS_CTL;
    wire        wr_iset  = wr && wb_adr_i == dtc_pkg::OFS_IEN_SET;
    wire        wr_iclr  = wr && wb_adr_i == dtc_pkg::OFS_IEN_CLR;
    wire        wr_msc   = wr && wb_adr_i == dtc_pkg::OFS_MSC;
    wire        wr_dbc   = wr && wb_adr_i == dtc_pkg::OFS_DEBOUNCE;
    wire [1:0]  wr_rel   = {wr && wb_adr_i == dtc_pkg::OFS_BRELOAD,
                            wr && wb_adr_i == dtc_pkg::OFS_ARELOAD};
    wire [1:0]  wr_cmp   = {wr && wb_adr_i == dtc_pkg::OFS_BCMP,
                            wr && wb_adr_i == dtc_pkg::OFS_ACMP};
    wire [1:0]  wr_div   = {wr && wb_adr_i == dtc_pkg::OFS_BDIV,
                            wr && wb_adr_i == dtc_pkg::OFS_ADIV};
    wire [31:0] wd_low   = wmask(32'h0000_0000, wb_dat_i, wb_sel_i);
    wire [31:0] ctl_wd   = wmask({16'h0000, ctl_r}, wb_dat_i, wb_sel_i);
    wire [15:0] masked   = raw_r & imask_r;

    logic [31:0] rd_mux;
    always_comb begin
        case (wb_adr_i)
            dtc_pkg::OFS_CFG:      rd_mux = {29'h0000_0000, cfg_r};
            dtc_pkg::OFS_AMODE:    rd_mux = {28'h000_0000, mode_r[0]};
            dtc_pkg::OFS_BMODE:    rd_mux = {28'h000_0000, mode_r[1]};
            dtc_pkg::OFS_CTL:      rd_mux = {16'h0000, ctl_r};
            dtc_pkg::OFS_IMASK:    rd_mux = {16'h0000, imask_r};
            dtc_pkg::OFS_RAW:      rd_mux = {16'h0000, raw_r};
            dtc_pkg::OFS_MSC:      rd_mux = {16'h0000, masked};
            dtc_pkg::OFS_ARELOAD:  rd_mux = reload_r[0];
            dtc_pkg::OFS_BRELOAD:  rd_mux = reload_r[1];
            dtc_pkg::OFS_ACMP:     rd_mux = cmp_r[0];
            dtc_pkg::OFS_BCMP:     rd_mux = cmp_r[1];
            dtc_pkg::OFS_ADIV:     rd_mux = div_r[0];
            dtc_pkg::OFS_BDIV:     rd_mux = div_r[1];
            dtc_pkg::OFS_DEBOUNCE: rd_mux = dbc_r;
            dtc_pkg::OFS_ACOUNT:   rd_mux = count_r[0];
            dtc_pkg::OFS_BCOUNT:   rd_mux = count_r[1];
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r   <= req;
            rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_r   <= 3'h0;
            ctl_r   <= 16'h0000;
            imask_r <= 16'h0000;
            dbc_r   <= dtc_pkg::RST_ZERO;
        end else begin
            if (wr_cfg)
                cfg_r <= wd_low[2:0];
            ctl_r <= (wr_ctl ? ctl_wd[15:0] : ctl_r)
                     & ~{7'h00, run_done[1], 7'h00, run_done[0]};
            if (wr_iset | wr_iclr)
                imask_r <= (imask_r | (wr_iset ? wd_low[15:0] : 16'h0000))
                         & ~(wr_iclr ? wd_low[15:0] : 16'h0000);
            if (wr_dbc)
                dbc_r <= wmask(dbc_r, wb_dat_i, wb_sel_i);
        end
    end

    // ========================================================================
    // Per-timer logic.
    logic [15:0] raw_set;
    wire         cap_mode = cfg_r == dtc_pkg::CFG_CAPTURE;
    wire         pwm_mode = cfg_r == dtc_pkg::CFG_PWM;

    genvar n;
    generate
        for (n = 0; n < 2; n++) begin : g_tmr
            localparam int CB = n * dtc_pkg::CTL_B_BASE;
            localparam int IB = n * dtc_pkg::IRQ_B_BASE;
            logic       s1_r, s2_r, s3_r, filt_r;
            logic [3:0] stab_r;
            wire        en   = ctl_r[CB + dtc_pkg::CTL_EN];
            wire [1:0]  evt  = ctl_r[CB + dtc_pkg::CTL_EVT +: 2];
            wire        inv  = ctl_r[CB + dtc_pkg::CTL_INV];
            wire        alternate_mode_select  = mode_r[n][dtc_pkg::MR_AMS];
            wire        cms  = mode_r[n][dtc_pkg::MR_CMS];
            wire [1:0]  md   = mode_r[n][1:0];
            wire        capm = cap_mode && !alternate_mode_select
                               && md == dtc_pkg::MODE_CAPTURE;
            wire        ecnt = capm && !cms;
            wire        etim = capm && cms;
            wire        pgen = pwm_mode && alternate_mode_select && !cms
                               && (md == dtc_pkg::MODE_TRI
                                   || md == dtc_pkg::MODE_DOWN);
            // Debounce holds the sampled level until it stays stable.
            wire        dben = dbc_r[dtc_pkg::DBC_EN];
            wire        stbl = s2_r == s3_r;
            wire        dbok = !dben || stab_r == dbc_r[4:1];
            wire        rise = !filt_r && s3_r && stbl && dbok;
            wire        fall = filt_r && !s3_r && stbl && dbok;
            wire        edg  = (evt == dtc_pkg::EVT_RISE && rise)
                               || (evt == dtc_pkg::EVT_FALL && fall)
                               || (evt == dtc_pkg::EVT_BOTH
                                   && (rise || fall));
            wire        go   = en && run_r[n];
            wire [15:0] rl   = reload_r[n][15:0];
            wire [15:0] cv   = cmp_r[n][15:0];
            wire        last = evt_left_r[n] == 16'h0001;
            assign run_done[n] = go && ecnt && edg && last;
            assign raw_set[IB + dtc_pkg::IRQ_CM] = run_done[n];
            assign raw_set[IB + dtc_pkg::IRQ_CE] = go && etim && edg;
            assign raw_set[IB + dtc_pkg::IRQ_TO] = go && etim
                && evt == dtc_pkg::EVT_BOTH
                && (rise || cnt_r[n] == 16'h0000);
            if (n == 0) begin : g_pad
                assign raw_set[7:3] = 5'h00;
            end else begin : g_padb
                assign raw_set[15:11] = 5'h00;
            end

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    filt_r <= 1'b0;
                    stab_r <= 4'h0;
                end else begin
                    s1_r <= cap_in[n];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    stab_r <= (stbl && s3_r != filt_r && !dbok)
                              ? stab_r + 4'h1 : 4'h0;
                    if (stbl && dbok)
                        filt_r <= s3_r;
                end
            end

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    mode_r[n]     <= 4'h0;
                    reload_r[n]   <= dtc_pkg::RST_RELOAD;
                    cmp_r[n]      <= dtc_pkg::RST_CMP;
                    div_r[n]      <= dtc_pkg::RST_DIV;
                    count_r[n]    <= dtc_pkg::RST_COUNT;
                    cnt_r[n]      <= 16'hffff;
                    evt_left_r[n] <= 16'h0000;
                    run_r[n]      <= 1'b0;
                    up_r[n]       <= 1'b0;
                    pwm_r[n]      <= 1'b0;
                end else begin
                    if ((n == 0 && wr_amode) || (n == 1 && wr_bmode))
                        mode_r[n] <= wd_low[3:0];
                    if (wr_rel[n])
                        reload_r[n] <= wmask(reload_r[n], wb_dat_i,
                                             wb_sel_i);
                    if (wr_cmp[n])
                        cmp_r[n] <= wmask(cmp_r[n], wb_dat_i, wb_sel_i);
                    if (wr_div[n])
                        div_r[n] <= wmask(div_r[n], wb_dat_i, wb_sel_i);
                    if (!en) begin
                        run_r[n]      <= 1'b1;
                        cnt_r[n]      <= rl;
                        evt_left_r[n] <= cv;
                        up_r[n]       <= 1'b0;
                        pwm_r[n]      <= 1'b0;
                    end else if (run_r[n]) begin
                        if (ecnt && edg) begin
                            cnt_r[n]      <= cnt_r[n] - 16'h0001;
                            evt_left_r[n] <= evt_left_r[n] - 16'h0001;
                            count_r[n]    <= {16'h0000, cnt_r[n] - 16'h0001};
                            if (last)
                                run_r[n] <= 1'b0;
                        end else if (etim) begin
                            cnt_r[n] <= (cnt_r[n] == 16'h0000
                                         || (evt == dtc_pkg::EVT_BOTH
                                             && rise))
                                        ? rl : cnt_r[n] - 16'h0001;
                            if (edg && evt == dtc_pkg::EVT_BOTH) begin
                                if (rise)
                                    count_r[n][14:0] <= cnt_r[n][14:0];
                                else
                                    count_r[n][30:16] <= cnt_r[n][14:0];
                            end else if (edg)
                                count_r[n] <= {16'h0000, cnt_r[n]};
                        end else if (pgen) begin
                            if (md == dtc_pkg::MODE_DOWN || !up_r[n])
                                cnt_r[n] <= (cnt_r[n] == 16'h0000)
                                    ? (md == dtc_pkg::MODE_DOWN
                                       ? rl : 16'h0001)
                                    : cnt_r[n] - 16'h0001;
                            else
                                cnt_r[n] <= (cnt_r[n] >= rl)
                                    ? cnt_r[n] - 16'h0001
                                    : cnt_r[n] + 16'h0001;
                            if (md == dtc_pkg::MODE_TRI
                                && cnt_r[n] == 16'h0000)
                                up_r[n] <= 1'b1;
                            else if (cnt_r[n] >= rl)
                                up_r[n] <= 1'b0;
                            count_r[n] <= {16'h0000, cnt_r[n]};
                            if (cnt_r[n] == rl)
                                pwm_r[n] <= 1'b1;
                            else if (cnt_r[n] == cv)
                                pwm_r[n] <= 1'b0;
                        end
                    end
                end
            end

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n)
                    pwm_out[n] <= 1'b0;
                else
                    pwm_out[n] <= (pgen && en) ? pwm_r[n] ^ inv : inv;
            end

            a_match_stops: assert property (@(posedge clk) disable iff (!reset_n)
                run_done[n] |=> !ctl_r[CB] && raw_r[IB + 1])
                else $error("edge count did not stop on match");
            a_pwm_no_status: assert property (@(posedge clk) disable iff (!reset_n)
                pgen |-> raw_set[IB +: 3] == 3'b000)
                else $error("pwm mode raised a status bit");
            a_etime_latch: assert property (@(posedge clk) disable iff (!reset_n)
                (go && etim && edg && evt != dtc_pkg::EVT_BOTH)
                |=> count_r[n][15:0] == $past(cnt_r[n]))
                else $error("edge time not latched");
            a_pwm_invert: assert property (@(posedge clk) disable iff (!reset_n)
                !en |=> pwm_out[n] == $past(inv))
                else $error("idle pwm level ignores polarity");
            c_pwm_high: cover property (@(posedge clk) pgen && pwm_r[n]);
            c_match: cover property (@(posedge clk) run_done[n]);
            a_debounce_hold: assert property (
                @(posedge clk) disable iff (!reset_n)
                (dben && !dbok) |=> filt_r == $past(filt_r))
                else $error("debounce let an unsteady level through");
            a_tri_turn: assert property (
                @(posedge clk) disable iff (!reset_n)
                (go && pgen && md == dtc_pkg::MODE_TRI
                 && cnt_r[n] == 16'h0000)
                |=> (cnt_r[n] == 16'h0001 && up_r[n]))
                else $error("triangle count did not turn at zero");
            a_pwm_set: assert property (
                @(posedge clk) disable iff (!reset_n)
                (go && pgen && cnt_r[n] == rl) |=> pwm_r[n])
                else $error("pwm did not assert at reload");
            a_detect_rise: assert property (
                @(posedge clk) disable iff (!reset_n)
                (go && etim && evt == dtc_pkg::EVT_BOTH && rise)
                |=> (count_r[n][14:0] == $past(cnt_r[n][14:0])
                     && cnt_r[n] == $past(rl)))
                else $error("rising edge capture or reload missed");
            c_tri_turn: cover property (@(posedge clk) pgen && up_r[n]);
        end
    endgenerate

    // ========================================================================
    // Status and interrupt.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            raw_r <= 16'h0000;
            irq_r <= 1'b0;
        end else begin
            raw_r <= (raw_r & ~(wr_msc ? wd_low[15:0] : 16'h0000))
                     | raw_set;
            irq_r <= |masked;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
    assign irq      = irq_r;

    a_clear_match: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_msc && wd_low[dtc_pkg::IRQ_CM] && !raw_set[dtc_pkg::IRQ_CM])
        |=> !raw_r[dtc_pkg::IRQ_CM])
        else $error("match flag not cleared");
    a_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
        raw_set[dtc_pkg::IRQ_CE] |=> raw_r[dtc_pkg::IRQ_CE])
        else $error("capture event flag lost");
    a_irq_follows: assert property (@(posedge clk) disable iff (!reset_n)
        (raw_r[dtc_pkg::IRQ_CM] && imask_r[dtc_pkg::IRQ_CM]) |=> irq)
        else $error("enabled match did not interrupt");
    a_mask_update: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_iset && wd_low[dtc_pkg::IRQ_TO] && !wr_iclr)
        |=> imask_r[dtc_pkg::IRQ_TO])
        else $error("enable set not visible");
    a_ack_once: assert property (@(posedge clk) disable iff (!reset_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    c_capture_cfg: cover property (@(posedge clk) cap_mode && irq);
    c_bus_read: cover property (@(posedge clk) wb_ack_o && !wb_we_i);
endmodule
`default_nettype wire

// ### shared/dtc_pkg.sv
// Package of register offsets, field positions and reset values for the dual timer.
package dtc_pkg;
    localparam logic [7:0]  OFS_CFG      = 8'h00;
    localparam logic [7:0]  OFS_AMODE    = 8'h04;
    localparam logic [7:0]  OFS_BMODE    = 8'h08;
    localparam logic [7:0]  OFS_CTL      = 8'h0c;
    localparam logic [7:0]  OFS_IEN_SET  = 8'h10;
    localparam logic [7:0]  OFS_IEN_CLR  = 8'h14;
    localparam logic [7:0]  OFS_IMASK    = 8'h18;
    localparam logic [7:0]  OFS_RAW      = 8'h1c;
    localparam logic [7:0]  OFS_MSC      = 8'h20;
    localparam logic [7:0]  OFS_ARELOAD  = 8'h28;
    localparam logic [7:0]  OFS_BRELOAD  = 8'h2c;
    localparam logic [7:0]  OFS_ACMP     = 8'h30;
    localparam logic [7:0]  OFS_BCMP     = 8'h34;
    localparam logic [7:0]  OFS_ADIV     = 8'h38;
    localparam logic [7:0]  OFS_BDIV     = 8'h3c;
    localparam logic [7:0]  OFS_DEBOUNCE = 8'h40;
    localparam logic [7:0]  OFS_ACOUNT   = 8'h48;
    localparam logic [7:0]  OFS_BCOUNT   = 8'h4c;

    localparam logic [2:0]  CFG_CAPTURE  = 3'h6;
    localparam logic [2:0]  CFG_PWM      = 3'h7;
    localparam logic [1:0]  MODE_TRI     = 2'h0;
    localparam logic [1:0]  MODE_DOWN    = 2'h2;
    localparam logic [1:0]  MODE_CAPTURE = 2'h3;
    localparam logic [1:0]  EVT_RISE     = 2'h0;
    localparam logic [1:0]  EVT_FALL     = 2'h1;
    localparam logic [1:0]  EVT_BOTH     = 2'h3;

    // Mode register fields.
    localparam int          MR_AMS       = 3;
    localparam int          MR_CMS       = 2;
    // Control register fields, per timer n: base 0 for A, 8 for B.
    localparam int          CTL_EN       = 0;
    localparam int          CTL_EVT      = 2;
    localparam int          CTL_INV      = 6;
    localparam int          CTL_B_BASE   = 8;
    // Interrupt bits: timeout, count match, capture event; A at 0, B at 8.
    localparam int          IRQ_TO       = 0;
    localparam int          IRQ_CM       = 1;
    localparam int          IRQ_CE       = 2;
    localparam int          IRQ_B_BASE   = 8;
    // Debounce: bit 0 enables, bits 4..1 give the stable-count length.
    localparam int          DBC_EN       = 0;

    localparam logic [31:0] RST_RELOAD   = 32'hffff_ffff;
    localparam logic [31:0] RST_COUNT    = 32'hffff_ffff;
    localparam logic [31:0] RST_CMP      = 32'h0000_ffff;
    localparam logic [31:0] RST_DIV      = 32'h0000_ffff;
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
endpackage

// ### verification/dtc_far_end.sv
// Far-side model: capture pulse source and PWM load monitor.
`timescale 1ns/100ps
`default_nettype none
module dtc_far_end (
    input  wire logic       clk,
    output logic      [1:0] cap_in,
    input  wire logic [1:0] pwm_out
);
    // =========================================================
    // Pulse source and high-time meter.
    initial cap_in = 2'h0;
    // Each pulse is held high four clocks after its edge, then low five clocks before the next.
    task automatic pulses(input int ch, input int n);
        repeat (n) begin
            @(posedge clk) cap_in[ch] <= 1'b1;
            repeat (4) @(posedge clk);
            cap_in[ch] <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic measure(input int ch, input int len, output int hi);
        hi = 0;
        repeat (len) begin
            @(posedge clk);
            if (pwm_out[ch] === 1'b1) hi++;
        end
    endtask
endmodule
`default_nettype wire

// ### verification/dual_timer_capture_pwm_test.sv
// Self-checking bench for the dual capture and PWM timer.
`timescale 1ns/100ps
`default_nettype none
module dual_timer_capture_pwm_test;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [1:0]  cap_in;
    logic [1:0]  pwm_out;
    logic        irq;
    int          mismatches = 0;
    int          total_checks = 0;
    int          hi;
    int          ev;
    logic [7:0]  ofs [11] = '{dtc_pkg::OFS_ARELOAD, dtc_pkg::OFS_BRELOAD,
        dtc_pkg::OFS_ACMP, dtc_pkg::OFS_BCMP, dtc_pkg::OFS_ADIV,
        dtc_pkg::OFS_BDIV, dtc_pkg::OFS_ACOUNT, dtc_pkg::OFS_BCOUNT,
        dtc_pkg::OFS_CFG, dtc_pkg::OFS_CTL, 8'h44};
    logic [31:0] rst [11] = '{dtc_pkg::RST_RELOAD, dtc_pkg::RST_RELOAD,
        dtc_pkg::RST_CMP, dtc_pkg::RST_CMP, dtc_pkg::RST_DIV,
        dtc_pkg::RST_DIV, dtc_pkg::RST_COUNT, dtc_pkg::RST_COUNT,
        dtc_pkg::RST_ZERO, dtc_pkg::RST_ZERO, dtc_pkg::RST_ZERO};
    logic [1:0]  evt [3] = '{dtc_pkg::EVT_RISE, dtc_pkg::EVT_FALL,
        dtc_pkg::EVT_BOTH};

    dtc_timer u_dtc_timer (.clk(clk), .reset_n(reset_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cap_in(cap_in),
        .pwm_out(pwm_out), .irq(irq));
    dtc_far_end u_dtc_far_end (.clk(clk), .cap_in(cap_in),
        .pwm_out(pwm_out));

    always #5 clk = ~clk;

    // =========================================================
    // Bus cycles, comparison and closing.
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    task automatic finish_test;
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test;
    end

    // =========================================================
    // Tests.
    initial begin
        logic [31:0] q;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 11; i++) rdc("reset", ofs[i], rst[i]);
        wr(dtc_pkg::OFS_IEN_SET, 32'h0000_0707);
        wr(dtc_pkg::OFS_IEN_CLR, 32'h0000_0005);
        rdc("mask", dtc_pkg::OFS_IMASK, 32'h0000_0702);
        wr(dtc_pkg::OFS_CFG, 32'h6);
        wr(dtc_pkg::OFS_AMODE, 32'h3);
        wr(dtc_pkg::OFS_ACMP, 32'h3);
        for (int i = 0; i < 3; i++) begin
            ev = (i == 2) ? 3 : 2;
            wr(dtc_pkg::OFS_CTL, 32'h0);
            wr(dtc_pkg::OFS_ARELOAD, 32'h10);
            wr(dtc_pkg::OFS_CTL, {28'h0, evt[i], 2'h1});
            u_dtc_far_end.pulses(0, 2);
            rdc("acount", dtc_pkg::OFS_ACOUNT, 32'(16 - ev));
            rdc("raw", dtc_pkg::OFS_RAW, (ev == 3) ? 32'h2 : 32'h0);
        end
        rdc("run", dtc_pkg::OFS_CTL, 32'hc);
        chk("irq", 32'h1, {31'h0, irq});
        rdc("msc", dtc_pkg::OFS_MSC, 32'h2);
        wr(dtc_pkg::OFS_MSC, 32'h2);
        rdc("raw", dtc_pkg::OFS_RAW, 32'h0);
        wr(dtc_pkg::OFS_DEBOUNCE, 32'h7);
        wr(dtc_pkg::OFS_CTL, 32'h1);
        u_dtc_far_end.pulses(0, 2);
        rdc("dbc", dtc_pkg::OFS_ACOUNT, 32'd13);
        wr(dtc_pkg::OFS_CTL, 32'h0);
        wr(dtc_pkg::OFS_DEBOUNCE, 32'h0);
        wr(dtc_pkg::OFS_BMODE, 32'h7);
        wr(dtc_pkg::OFS_CTL, 32'h0000_0500);
        u_dtc_far_end.pulses(1, 1);
        rdc("raw", dtc_pkg::OFS_RAW, 32'h400);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b0, dtc_pkg::OFS_BCOUNT, 32'h0, q);
        chk("moved", 32'h1, {31'h0, q[15:0] !== 16'hffff});
        wr(dtc_pkg::OFS_MSC, 32'h400);
        rdc("raw", dtc_pkg::OFS_RAW, 32'h0);
        wr(dtc_pkg::OFS_CTL, 32'h0);
        wr(dtc_pkg::OFS_CFG, 32'h7);
        wr(dtc_pkg::OFS_AMODE, 32'ha);
        wr(dtc_pkg::OFS_ARELOAD, 32'h9);
        wr(dtc_pkg::OFS_ACMP, 32'h3);
        wr(dtc_pkg::OFS_CTL, 32'h1);
        repeat (20) @(posedge clk);
        u_dtc_far_end.measure(0, 100, hi);
        chk("high", 32'd60, 32'(hi));
        rdc("raw", dtc_pkg::OFS_RAW, 32'h0);
        wr(dtc_pkg::OFS_CTL, 32'h0);
        wr(dtc_pkg::OFS_CTL, 32'h41);
        repeat (20) @(posedge clk);
        u_dtc_far_end.measure(0, 100, hi);
        chk("inv", 32'd40, 32'(hi));
        wr(dtc_pkg::OFS_ACMP, 32'h5);
        repeat (20) @(posedge clk);
        u_dtc_far_end.measure(0, 100, hi);
        chk("cmp", 32'd60, 32'(hi));
        wr(dtc_pkg::OFS_CTL, 32'h0);
        wr(dtc_pkg::OFS_AMODE, 32'h8);
        wr(dtc_pkg::OFS_ACMP, 32'h3);
        wr(dtc_pkg::OFS_CTL, 32'h1);
        repeat (20) @(posedge clk);
        u_dtc_far_end.measure(0, 90, hi);
        chk("tri", 32'd30, 32'(hi));
        wr(dtc_pkg::OFS_CTL, 32'h0);
        wr(dtc_pkg::OFS_CFG, 32'h6);
        wr(dtc_pkg::OFS_IEN_CLR, 32'h0000_0400);
        wr(dtc_pkg::OFS_CTL, 32'h0000_0d00);
        u_dtc_far_end.pulses(1, 1);
        rdc("raw", dtc_pkg::OFS_RAW, 32'h500);
        rdc("msc", dtc_pkg::OFS_MSC, 32'h100);
        bus(1'b0, dtc_pkg::OFS_BCOUNT, 32'h0, q);
        chk("width", 32'h7ffc, {17'h0, q[30:16]});
        finish_test;
    end
endmodule
`default_nettype wire
